/* File: hw/clock_generation_unit.sv */
// clock generation unit: clocks, slow divider, watchdog, periodic tick, monitor
`timescale 1ns/1ps
module clock_generation_unit import clock_unit_pkg::*; #(
  parameter int WDOG_BASE_SHIFT = 13, // watchdog prescale, 2^13 bus cycles
  parameter int PERIODIC_BASE_SHIFT = 13 // shortest periodic period, 2^13 bus cycles
) (
  input wire logic pclk, // oscillator reference, 100 MHz
  input wire logic presetn, // power-on reset, asynchronous, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [15:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped offset or address outside the block region
  input wire logic [4:0] block_base, // 2-Kbyte region of the register block
  input wire logic wait_mode, // part is in wait mode (pin)
  input wire logic ext_reset_n, // external reset request (pin), active low
  input wire logic osc_sense, // raw oscillator edge sense for the monitor (pin)
  output logic p_clk_glob, // global peripheral clock
  output logic e_clk_glob, // global bus clock
  output logic p_clk_full, // full rate pair, peripheral clock
  output logic e_clk_full, // full rate pair, bus clock
  output logic [3:0] t_clk, // processor phase clocks
  output logic sys_reset_n, // system reset, active low
  output logic por_active, // power-on reset sequence running
  output logic periodic_irq // periodic interrupt request
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] wait_sync;
  logic [1:0] ext_sync;
  logic [2:0] osc_sync;
  logic in_wait;
  logic ext_req;
  logic osc_edge;

  // the first stage of each chain is read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_sync <= 2'h0;
      ext_sync <= 2'h3;
      osc_sync <= 3'h0;
    end else begin
      wait_sync <= {wait_sync[0], wait_mode};
      ext_sync <= {ext_sync[0], ext_reset_n};
      osc_sync <= {osc_sync[1:0], osc_sense};
    end
  end

  assign in_wait = wait_sync[1];
  assign ext_req = !ext_sync[1];
  assign osc_edge = osc_sync[2] ^ osc_sync[1];

  // ----------------------------------------------------------------
  // registers and reset sequencer state
  // ----------------------------------------------------------------
  logic [2:0] slow_divider_field;
  logic periodic_interrupt_enable;
  logic [2:0] periodic_rate_field;
  logic periodic_flag;
  logic monitor_enable_bit;
  logic [2:0] watchdog_rate_field;
  logic [4:0] reset_cause;
  logic [7:0] rst_count;
  logic seq_busy;
  logic chip_reset;
  logic wdog_timeout;
  logic mon_timeout;
  logic svc_restart;
  logic svc_illegal;
  logic periodic_tick;
  logic reset_request;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic in_block;
  logic [10:0] offset;
  logic mapped;
  logic wr_strobe;
  logic rd_strobe;

  assign in_block = (paddr[15:11] == block_base);
  assign offset = {paddr[10:2], 2'h0};
  assign mapped = in_block && (offset == OFS_SLOW || offset == OFS_PERIODIC_CTL ||
                  offset == OFS_PERIODIC_FLAG || offset == OFS_WATCHDOG_CTL ||
                  offset == OFS_WATCHDOG_SVC || offset == OFS_STATUS);
  assign wr_strobe = psel && penable && pwrite && mapped;
  assign rd_strobe = psel && penable && !pwrite;
  // every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // read data registered at the access edge would cost a cycle, so it is muxed
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_strobe && mapped) begin
      case (offset)
        OFS_SLOW: prdata = {29'h0, slow_divider_field};
        OFS_PERIODIC_CTL: prdata = {24'h0, periodic_interrupt_enable, 4'h0,
                                    periodic_rate_field};
        OFS_PERIODIC_FLAG: prdata = {24'h0, periodic_flag, 7'h00};
        OFS_WATCHDOG_CTL: prdata = {24'h0, monitor_enable_bit, 4'h0,
                                    watchdog_rate_field};
        OFS_STATUS: prdata = {27'h0, reset_cause[4:1], in_wait};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control registers, returned to reset values by any chip reset
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_divider_field <= RESET_FIELD;
      periodic_interrupt_enable <= 1'b0;
      periodic_rate_field <= RESET_FIELD;
      monitor_enable_bit <= 1'b0;
      watchdog_rate_field <= RESET_FIELD;
    end else if (chip_reset) begin
      slow_divider_field <= RESET_FIELD;
      periodic_interrupt_enable <= 1'b0;
      periodic_rate_field <= RESET_FIELD;
      monitor_enable_bit <= 1'b0;
      watchdog_rate_field <= RESET_FIELD;
    end else if (wr_strobe) begin
      case (offset)
        OFS_SLOW: slow_divider_field <= pwdata[2:0];
        OFS_PERIODIC_CTL: begin
          periodic_interrupt_enable <= pwdata[BIT_ENABLE];
          periodic_rate_field <= pwdata[2:0];
        end
        OFS_WATCHDOG_CTL: begin
          monitor_enable_bit <= pwdata[BIT_ENABLE];
          watchdog_rate_field <= pwdata[2:0];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // clock generation
  // ----------------------------------------------------------------
  logic [1:0] phase;
  logic slow_active;
  logic slow_tick;
  logic glob_tick;
  logic bus_tick;

  // four phase slots per four oscillator cycles, one processor clock each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 2'h0;
      t_clk <= 4'h1;
    end else begin
      phase <= phase + 2'h1;
      t_clk <= 4'(4'h1 << (phase + 2'h1));
    end
  end

  // the full rate pair toggles on every rising edge: oscillator over two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e_clk_full <= 1'b0;
      p_clk_full <= 1'b1;
    end else begin
      e_clk_full <= !e_clk_full;
      p_clk_full <= e_clk_full;
    end
  end

  // slowing only applies in wait mode with a nonzero field
  assign slow_active = in_wait && (slow_divider_field != 3'h0);

  // counter runs from the constant clock; shift n gives 2^n slower toggles
  tick_divider #(.W(8)) u_slow_div (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!slow_active),
    .tick_in(1'b1),
    .shift({2'h0, slow_divider_field}),
    .tick_out(slow_tick)
  );

  assign glob_tick = slow_active ? slow_tick : 1'b1;
  // one bus cycle ends each time the global bus clock falls
  assign bus_tick = glob_tick && e_clk_glob;

  // the global pair follows the divider in wait, the oscillator otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e_clk_glob <= 1'b0;
      p_clk_glob <= 1'b1;
    end else if (glob_tick) begin
      e_clk_glob <= !e_clk_glob;
      p_clk_glob <= e_clk_glob;
    end
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  logic [4:0] wdog_shift;
  logic wdog_on;
  logic wdog_clear;
  logic svc_wr;

  assign svc_wr = wr_strobe && (offset == OFS_WATCHDOG_SVC);

  watchdog_service u_service (
    .pclk(pclk),
    .presetn(presetn),
    .clear(chip_reset),
    .wr(svc_wr),
    .wdata(pwdata[7:0]),
    .restart(svc_restart),
    .illegal(svc_illegal)
  );

  // base prescale then two further powers of two per code up to code 5, one per code above; code 0 is off
  always_comb begin
    case (watchdog_rate_field)
      3'h1: wdog_shift = 5'(WDOG_BASE_SHIFT);
      3'h2: wdog_shift = 5'(WDOG_BASE_SHIFT + 2);
      3'h3: wdog_shift = 5'(WDOG_BASE_SHIFT + 4);
      3'h4: wdog_shift = 5'(WDOG_BASE_SHIFT + 6);
      3'h5: wdog_shift = 5'(WDOG_BASE_SHIFT + 8);
      3'h6: wdog_shift = 5'(WDOG_BASE_SHIFT + 9);
      3'h7: wdog_shift = 5'(WDOG_BASE_SHIFT + 10);
      default: wdog_shift = 5'h00;
    endcase
  end

  assign wdog_on = (watchdog_rate_field != 3'h0);
  // a valid service pair restarts the free-running count
  assign wdog_clear = chip_reset || !wdog_on || svc_restart;

  tick_divider #(.W(DIV_CNT_W)) u_wdog_div (
    .pclk(pclk),
    .presetn(presetn),
    .clear(wdog_clear),
    .tick_in(bus_tick),
    .shift(wdog_shift),
    .tick_out(wdog_timeout)
  );

  // ----------------------------------------------------------------
  // periodic interrupt
  // ----------------------------------------------------------------
  logic [4:0] periodic_shift;
  logic periodic_on;
  logic flag_clear;

  assign periodic_on = (periodic_rate_field != 3'h0);
  assign periodic_shift = 5'(PERIODIC_BASE_SHIFT - 1 + int'(periodic_rate_field));

  // periods count bus cycles, so the slow divider stretches them too
  tick_divider #(.W(DIV_CNT_W)) u_periodic_div (
    .pclk(pclk),
    .presetn(presetn),
    .clear(chip_reset || !periodic_on),
    .tick_in(bus_tick),
    .shift(periodic_shift),
    .tick_out(periodic_tick)
  );

  assign flag_clear = wr_strobe && (offset == OFS_PERIODIC_FLAG) && pwdata[BIT_FLAG];

  // a timeout in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periodic_flag <= 1'b0;
    end else if (chip_reset) begin
      periodic_flag <= 1'b0;
    end else if (periodic_tick) begin
      periodic_flag <= 1'b1;
    end else if (flag_clear) begin
      periodic_flag <= 1'b0;
    end
  end

  assign periodic_irq = periodic_flag && periodic_interrupt_enable;

  // ----------------------------------------------------------------
  // clock monitor
  // ----------------------------------------------------------------
  logic [7:0] mon_count;

  // counts reference cycles between oscillator edges; a real part uses an
  // rc delay so it works with every clock stopped, this model needs pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_count <= 8'h00;
    end else if (!monitor_enable_bit || osc_edge || chip_reset) begin
      mon_count <= 8'h00;
    end else if (mon_count != 8'(CM_TIMEOUT_CYCLES)) begin
      mon_count <= mon_count + 8'h01;
    end
  end

  assign mon_timeout = monitor_enable_bit &&
                       (mon_count == 8'(CM_TIMEOUT_CYCLES));

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  assign reset_request = wdog_timeout || svc_illegal || mon_timeout || ext_req;
  assign chip_reset = seq_busy;

  // every source starts the same sequence; its end waits while the external request is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_busy <= 1'b1;
      por_active <= 1'b1;
      rst_count <= 8'h00;
      sys_reset_n <= 1'b0;
    end else if (reset_request && !seq_busy) begin
      seq_busy <= 1'b1;
      rst_count <= 8'h00;
      sys_reset_n <= 1'b0;
    end else if (seq_busy) begin
      if (rst_count == 8'(RST_SEQ_CYCLES - 1) && !ext_req) begin
        seq_busy <= 1'b0;
        por_active <= 1'b0;
        sys_reset_n <= 1'b1;
      end else if (rst_count != 8'(RST_SEQ_CYCLES - 1)) begin
        rst_count <= rst_count + 8'h01;
      end
    end
  end

  // cause of the last reset survives the sequence for software to read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_cause <= 5'h00;
    end else if (reset_request && !seq_busy) begin
      reset_cause[BIT_ST_WAIT] <= 1'b0;
      reset_cause[BIT_ST_WDOG] <= wdog_timeout;
      reset_cause[BIT_ST_MON] <= mon_timeout;
      reset_cause[BIT_ST_ILLEGAL] <= svc_illegal;
      reset_cause[BIT_ST_EXT] <= ext_req;
    end
  end
endmodule : clock_generation_unit

/* File: hw/clock_unit_pkg.sv */
// constants shared by the clock generation unit and its helpers
// Function
// - peripheral, bus and four processor phase clocks
// - generate and time system and power-on resets
// - wait mode global pair follows slow divider
// - full rate pair stays oscillator divided two
// - slow divider powers of two up to 128
// - divider off when field zero or running
// - monitor referenced to oscillator, not bus clock
// - watchdog timeout while enabled starts system reset
// - three bit rate: off or seven periods
// - any other service value resets at once
// - periodic interrupt with flag, enable, rate field
// - no oscillator edges within delay resets
// - monitor enable bit in watchdog control register
// - monitor delay runs without any chip clock (this model counts pclk instead)
// - registers relocatable to any 2-Kbyte region
// - field zero bypasses, n divides by 2^n
// - periodic rate divides bus by 2^13..2^19
// - periodic flag sets on timeout, write-one clears
// - watchdog counts bus over 2^13, field extends
package clock_unit_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CM_MIN_TIMEOUT_NS = 2000;
  localparam int CM_TIMEOUT_CYCLES = (CM_MIN_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_SEQ_CYCLES = 64;
  localparam int DIV_CNT_W = 24;
  // ----------------------------------------------------------------
  // register map (byte offsets inside the 2-Kbyte block)
  // ----------------------------------------------------------------
  localparam logic [10:0] OFS_SLOW = 11'h000;
  localparam logic [10:0] OFS_PERIODIC_CTL = 11'h004;
  localparam logic [10:0] OFS_PERIODIC_FLAG = 11'h008;
  localparam logic [10:0] OFS_WATCHDOG_CTL = 11'h00c;
  localparam logic [10:0] OFS_WATCHDOG_SVC = 11'h010;
  localparam logic [10:0] OFS_STATUS = 11'h014;
  localparam int BIT_ENABLE = 7;
  localparam int BIT_FLAG = 7;
  localparam int BIT_ST_WAIT = 0;
  localparam int BIT_ST_WDOG = 1;
  localparam int BIT_ST_MON = 2;
  localparam int BIT_ST_ILLEGAL = 3;
  localparam int BIT_ST_EXT = 4;
  localparam logic [2:0] RESET_FIELD = 3'h0;
  localparam logic [7:0] SVC_ARM = 8'h55;
  localparam logic [7:0] SVC_FIRE = 8'haa;
endpackage : clock_unit_pkg

/* File: hw/tick_divider.sv */
// power-of-two divider of a tick stream
`timescale 1ns/1ps
module tick_divider import clock_unit_pkg::*; #(
  parameter int W = DIV_CNT_W
) (
  input wire logic pclk, // oscillator reference clock
  input wire logic presetn, // asynchronous reset, active low
  input wire logic clear, // restart the count
  input wire logic tick_in, // one-cycle input tick
  input wire logic [4:0] shift, // divide by two to this power
  output logic tick_out // one pulse every 2^shift input ticks
);
  logic [W-1:0] count;
  logic [W-1:0] last;

  // terminal count is 2^shift - 1
  assign last = W'((64'h1 << shift) - 64'h1);

  // counter wraps at the terminal count and pulses on the wrap; a count left
  // above a newly shortened terminal wraps at once instead of running to 2^W
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      tick_out <= 1'b0;
    end else if (clear) begin
      count <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in && (count >= last);
      if (tick_in) begin
        count <= (count >= last) ? '0 : count + W'(1);
      end
    end
  end
endmodule : tick_divider

/* File: hw/watchdog_service.sv */
// watchdog service sequence checker
`timescale 1ns/1ps
module watchdog_service import clock_unit_pkg::*; (
  input wire logic pclk, // oscillator reference clock
  input wire logic presetn, // asynchronous reset, active low
  input wire logic clear, // chip reset in progress
  input wire logic wr, // one-cycle write to the service register
  input wire logic [7:0] wdata, // value written
  output logic restart, // pulse: arm then fire seen in order
  output logic illegal // pulse: a value other than the two
);
  logic armed;

  // an arm value must come first; a lone fire value is legal but does nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
      restart <= 1'b0;
      illegal <= 1'b0;
    end else if (clear) begin
      armed <= 1'b0;
      restart <= 1'b0;
      illegal <= 1'b0;
    end else begin
      restart <= wr && (wdata == SVC_FIRE) && armed;
      illegal <= wr && (wdata != SVC_ARM) && (wdata != SVC_FIRE);
      if (wr) begin
        armed <= (wdata == SVC_ARM);
      end
    end
  end
endmodule : watchdog_service

/* File: test/clock_unit_chk.sv */
// port assertions for the clock generation unit
`timescale 1ns/1ps
module clock_unit_chk import clock_unit_pkg::*; (
  input wire logic pclk, // reference clock
  input wire logic presetn, // power-on reset
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic [15:0] paddr, // apb address
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [4:0] block_base, // register region
  input wire logic wait_mode, // wait pin
  input wire logic e_clk_glob, // global bus clock
  input wire logic p_clk_glob, // global peripheral clock
  input wire logic p_clk_full, // full rate peripheral clock
  input wire logic e_clk_full, // full rate bus clock
  input wire logic [3:0] t_clk, // phase clocks
  input wire logic sys_reset_n, // system reset
  input wire logic por_active // power-on sequence
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] low_cnt;
  // length of the current reset sequence; a counter because it spans 64 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= sys_reset_n ? 8'h00 : low_cnt + 8'h01;
    end
  end
  chk_phase_walk: assert property (t_clk == 4'h1 |=> t_clk == 4'h2 ##1 t_clk == 4'h4
    ##1 t_clk == 4'h8 ##1 t_clk == 4'h1) else $error("phase clocks out of order");
  chk_glob_pair: assert property (p_clk_glob == !e_clk_glob)
    else $error("global pair out of phase");
  chk_full_pair: assert property (e_clk_full |-> !p_clk_full
    ##1 (!e_clk_full && p_clk_full)) else $error("full rate pair not at half oscillator");
  chk_glob_run: assert property ((!wait_mode) [*6] ##0 e_clk_glob |=> !e_clk_glob)
    else $error("bus clock divided outside wait");
  chk_seq_len: assert property ($rose(sys_reset_n) |-> low_cnt >= RST_SEQ_CYCLES)
    else $error("reset sequence too short");
  chk_por_end: assert property ($fell(por_active) |-> $rose(sys_reset_n))
    else $error("power-on flag ended apart from reset");
  chk_por_once: assert property (sys_reset_n |-> !por_active)
    else $error("power-on flag seen outside reset");
  chk_apb_ready: assert property (psel && penable |-> pready)
    else $error("access not answered");
  chk_other_block: assert property (psel && penable && paddr[15:11] != block_base
    |-> pslverr && prdata == 32'h0) else $error("foreign region answered");
  chk_block_hit: assert property (psel && penable && paddr[15:11] == block_base
    && paddr[10:0] <= OFS_STATUS && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped register refused");
endmodule : clock_unit_chk

bind clock_generation_unit clock_unit_chk i_clock_unit_chk (.pclk, .presetn, .psel,
  .penable, .paddr, .prdata, .pready, .pslverr, .block_base, .wait_mode, .e_clk_glob,
  .p_clk_glob, .p_clk_full, .e_clk_full, .t_clk, .sys_reset_n, .por_active);

/* File: test/testbench.sv */
// self-checking testbench for the clock generation unit
`timescale 1ns/1ps
module testbench import clock_unit_pkg::*; ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [4:0] block_base = 5'h03;
  logic wait_mode = 1'b0;
  logic ext_reset_n = 1'b1;
  logic osc_sense = 1'b0;
  logic osc_run = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, p_clk_glob, e_clk_glob, p_clk_full, e_clk_full;
  logic [3:0] t_clk;
  logic sys_reset_n, por_active, periodic_irq;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  // short prescalers keep every watchdog and periodic count within the run
  clock_generation_unit #(.WDOG_BASE_SHIFT(2), .PERIODIC_BASE_SHIFT(2))
    i_clock_generation_unit (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .block_base, .wait_mode, .ext_reset_n, .osc_sense, .p_clk_glob,
    .e_clk_glob, .p_clk_full, .e_clk_full, .t_clk, .sys_reset_n, .por_active,
    .periodic_irq);
  always #5 pclk = ~pclk;
  // cycle count, also the ceiling that cuts a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      final_report();
    end
  end
  // oscillator sense toggles every 8 cycles while running
  always @(posedge pclk) begin
    if (osc_run && cyc % 8 == 0) begin
      osc_sense <= ~osc_sense;
    end
  end
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  task automatic check(input string nm, input logic [31:0] x, input logic [31:0] got);
    total_checks++;
    if (got !== x) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, got);
    end
  endtask : check
  // one apb transfer, held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // pready seen high ends this wait; the bench ceiling ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [10:0] o, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, {block_base, o}, d, r, e);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [10:0] o, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, {block_base, o}, 32'h0, r, e);
    check(nm, x, r);
  endtask : rd_chk
  task automatic wait_rst(input logic lvl, input int lim, output int k);
    for (k = 0; k < lim && sys_reset_n !== lvl; k++) @(posedge pclk);
  endtask : wait_rst
  // after any reset cause: sequence ends, cause kept, watchdog control cleared
  task automatic recover(input logic [31:0] cause);
    int k;
    wait_rst(1'b1, 300, k);
    rd_chk("cause", OFS_STATUS, cause);
    rd_chk("wdog ctl cleared", OFS_WATCHDOG_CTL, 32'h0);
  endtask : recover
  task automatic half(output int k);
    logic e0;
    e0 = e_clk_glob;
    for (k = 0; k < 300 && e_clk_glob === e0; k++) @(posedge pclk);
    e0 = e_clk_glob;
    for (k = 0; k < 300 && e_clk_glob === e0; k++) @(posedge pclk);
  endtask : half
  task automatic irq_gap(output int g);
    int k, t;
    for (k = 0; k < 2100 && periodic_irq !== 1'b1; k++) @(posedge pclk);
    t = cyc;
    wr(OFS_PERIODIC_FLAG, 32'h80);
    for (k = 0; k < 2100 && periodic_irq !== 1'b1; k++) @(posedge pclk);
    g = cyc - t;
    wr(OFS_PERIODIC_FLAG, 32'h80);
  endtask : irq_gap
  task automatic t_start();
    int k;
    logic [31:0] r;
    logic e;
    check("por flag", 1'b1, por_active);
    wait_rst(1'b1, 200, k);
    check("reset length", RST_SEQ_CYCLES + 1, k);
    check("por flag end", 1'b0, por_active);
    rd_chk("slow rst", OFS_SLOW, 32'h0);
    rd_chk("periodic ctl rst", OFS_PERIODIC_CTL, 32'h0);
    rd_chk("status rst", OFS_STATUS, 32'h0);
    apb(1'b0, {block_base, 11'h018}, 32'h0, r, e);
    check("unmapped", 1'b1, e);
    wr(OFS_SLOW, 32'h5);
    block_base <= 5'h1f;
    apb(1'b0, {5'h03, OFS_SLOW}, 32'h0, r, e);
    check("old region", 1'b1, e);
    rd_chk("moved slow", OFS_SLOW, 32'h5);
  endtask : t_start
  task automatic t_slow();
    int n, k;
    wait_mode <= 1'b1;
    for (n = 0; n < 8; n++) begin
      wr(OFS_SLOW, n);
      half(k);
      half(k);
      check("glob half period", 1 << n, k);
    end
    rd_chk("in wait", OFS_STATUS, 32'h1);
    wait_mode <= 1'b0;
    half(k);
    half(k);
    check("run half period", 1, k);
    wr(OFS_SLOW, 32'h0);
  endtask : t_slow
  task automatic t_periodic();
    int c, g;
    wr(OFS_PERIODIC_CTL, 32'h7);
    repeat (600) @(posedge pclk);
    check("irq masked", 1'b0, periodic_irq);
    rd_chk("flag set", OFS_PERIODIC_FLAG, 32'h80);
    wr(OFS_PERIODIC_CTL, 32'h87);
    check("irq on", 1'b1, periodic_irq);
    wr(OFS_PERIODIC_FLAG, 32'h80);
    check("flag clear", 1'b0, periodic_irq);
    for (c = 1; c < 8; c++) begin
      wr(OFS_PERIODIC_CTL, 32'h80 | c);
      irq_gap(g);
      irq_gap(g);
      check("periodic period", 4 << c, g);
    end
    wr(OFS_PERIODIC_CTL, 32'h80);
    repeat (600) @(posedge pclk);
    check("periodic off", 1'b0, periodic_irq);
  endtask : t_periodic
  task automatic t_wdog();
    int c, k, t, x;
    int sh[8] = '{0, 0, 2, 4, 6, 8, 9, 10};
    for (c = 1; c < 8; c++) begin
      wr(OFS_WATCHDOG_SVC, SVC_ARM);
      wr(OFS_WATCHDOG_SVC, SVC_FIRE);
      wr(OFS_WATCHDOG_CTL, c);
      t = cyc;
      wait_rst(1'b0, 9000, k);
      x = 8 << sh[c];
      t = cyc - t;
      check("wdog timeout", 1, t inside {[x - 8 : x + 4]});
      recover(32'h2);
    end
  endtask : t_wdog
  task automatic t_service();
    int k, t;
    wr(OFS_WATCHDOG_SVC, SVC_ARM);
    wr(OFS_WATCHDOG_SVC, SVC_FIRE);
    wr(OFS_WATCHDOG_CTL, 32'h2);
    repeat (4) begin
      repeat (10) @(posedge pclk);
      wr(OFS_WATCHDOG_SVC, SVC_ARM);
      wr(OFS_WATCHDOG_SVC, SVC_FIRE);
    end
    t = cyc;
    check("serviced", 1'b1, sys_reset_n);
    repeat (10) @(posedge pclk);
    wr(OFS_WATCHDOG_SVC, SVC_FIRE);
    wait_rst(1'b0, 100, k);
    t = cyc - t;
    check("lone fire", 1, t inside {[28 : 38]});
    recover(32'h2);
    wr(OFS_WATCHDOG_CTL, 32'h3);
    wr(OFS_WATCHDOG_SVC, 32'h12);
    wait_rst(1'b0, 4, k);
    check("illegal value", 1'b0, sys_reset_n);
    recover(32'h8);
  endtask : t_service
  task automatic t_monitor();
    int k, t;
    repeat (400) @(posedge pclk);
    check("monitor off", 1'b1, sys_reset_n);
    osc_run <= 1'b1;
    wr(OFS_SLOW, 32'h7);
    wait_mode <= 1'b1;
    wr(OFS_WATCHDOG_CTL, 32'h80);
    repeat (600) @(posedge pclk);
    check("monitor fed", 1'b1, sys_reset_n);
    osc_run <= 1'b0;
    wait_mode <= 1'b0;
    t = cyc;
    wait_rst(1'b0, 400, k);
    t = cyc - t;
    check("monitor trip", 1, t inside {[194 : 208]});
    recover(32'h4);
    ext_reset_n <= 1'b0;
    repeat (3) @(posedge pclk);
    ext_reset_n <= 1'b1;
    wait_rst(1'b0, 8, k);
    recover(32'h10);
    check("por stays low", 1'b0, por_active);
  endtask : t_monitor
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_start();
    t_slow();
    t_periodic();
    t_wdog();
    t_service();
    t_monitor();
    final_report();
  end
endmodule : testbench
